// ===== verilog/dsrx_defs.svh
// Overview of operation
// - Line unit supplies clock; rails carry data.
// - Single-rail and dual-rail input formats selectable.
// - Single-rail takes NRZ on positive rail only.
// - Single-rail: high rail gives one, low zero.
// - Recovered line clock paces whole receive section.
// - Control bit 3 selects rail format.
// - Reset selects dual-rail operation.
// - Same bit sets transmit output format.
// - Dual-rail samples both rails, merges one stream.
// - Dual-rail decodes either AMI or B3ZS.
// - AMI: any pulse is one, none zero.
// - Same-polarity successive marks are bipolar violations.
// - Control bit 1 picks rising or falling edge.
// - B3ZS: 00V or B0V becomes three zeros.
// - Invalid violation flags a line code violation.
`ifndef DSRX_DEFS_SVH
`define DSRX_DEFS_SVH

// ==========================================================
// Register indices; the byte address is four times the index.
`define DSRX_IDX_IOCTL 6'h01
`define DSRX_IDX_ISTS 6'h02
`define DSRX_IDX_IMSK 6'h03
`define DSRX_IDX_LCVCNT 6'h04

// ==========================================================
// Fields of the line interface control register.
`define DSRX_IOC_REFRAME 0
`define DSRX_IOC_RXINV 1
`define DSRX_IOC_TXINV 2
`define DSRX_IOC_SINGLE 3
`define DSRX_IOC_AMI 4
`define DSRX_IOC_DISRXLOC 5
`define DSRX_IOC_LOC 6
`define DSRX_IOC_DISTXLOC 7
`define DSRX_IOC_RESET 8'hA0
`define DSRX_IOC_WMASK 8'hBF

// ==========================================================
// Interrupt status and mask fields.
`define DSRX_INT_LCV 0
`define DSRX_INT_SUBST 1
`define DSRX_INT_W 2
`define DSRX_INT_RESET 2'h0

// ==========================================================
// Bus answers and B3ZS zero-run limit.
`define DSRX_RESP_OKAY 2'h0
`define DSRX_RESP_SLVERR 2'h2
`define DSRX_ZRUN_MAX 2'h3

`endif

// ===== verilog/dsrx_pkg.sv
`default_nettype none
package dsrx_pkg;

  // ========================================================
  // Register selection after address decode.
  typedef enum logic [2:0] {
    DSRX_REG_NONE,
    DSRX_REG_IOCTL,
    DSRX_REG_ISTS,
    DSRX_REG_IMSK,
    DSRX_REG_LCVCNT
  } dsrx_reg_e;

  // One sampled line symbol.
  typedef struct packed {
    logic pos;
    logic neg;
  } dsrx_sym_s;

  // Synchroniser stages for line clock and both rails.
  typedef struct packed {
    logic clk;
    dsrx_sym_s sym;
  } dsrx_line_s;

endpackage : dsrx_pkg
`default_nettype wire

// ===== verilog/dsrx_line_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsrx_defs.svh"

module dsrx_line_rx
  import dsrx_pkg::*;
#(
  parameter int LCV_CNT_W = 16
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Line pins from the line interface unit.
  input wire logic rx_recovered_line_clock,
  input wire logic rx_positive_rail,
  input wire logic rx_negative_rail,
  // Decoded stream towards the framer.
  output logic rx_data,
  output logic rx_data_valid,
  output logic rx_line_code_violation,
  // Settings shared with the transmit side, and the interrupt.
  output logic tx_single_rail,
  output logic tx_clk_invert,
  output logic irq,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ========================================================
  // Parameter check.
  generate
    if (LCV_CNT_W < 1 || LCV_CNT_W > 32) begin : g_bad_width
      $error("LCV_CNT_W must lie between 1 and 32.");
    end
  endgenerate

  // ========================================================
  // All state of the block in one packed struct.
  typedef struct packed {
    dsrx_line_s meta;           // First synchroniser stage.
    dsrx_line_s sync;           // Second synchroniser stage.
    logic clk_d;                // Delayed clock for edge detect.
    logic [7:0] ioc;            // Line interface control.
    logic [2:0] pipe;           // Three decoded bits, [2] oldest.
    logic last_neg;             // Polarity of the previous mark.
    logic seen_mark;            // A mark has been seen.
    logic [1:0] zrun;           // Run of zero symbols.
    logic dout;                 // Output data bit.
    logic dvalid;               // Output strobe.
    logic lcv_p;                // Violation pulse.
    logic [`DSRX_INT_W-1:0] ists;
    logic [`DSRX_INT_W-1:0] imsk;
    logic [LCV_CNT_W-1:0] lcv_cnt;
    logic aw_ok;                // Write address held.
    logic [5:0] aw_idx;
    logic w_ok;                 // Write data held.
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dsrx_state_s;

  dsrx_state_s st_r;            // Registered state.
  dsrx_state_s st_nxt;          // Next state.
  logic rise_w;                 // Rising line clock edge seen.
  logic fall_w;                 // Falling line clock edge seen.
  logic take_w;                 // Symbol sampled this cycle.
  logic viol_w;                 // Same-polarity mark detected.
  logic sub_w;                  // Valid B3ZS substitution.
  logic lcv_w;                  // Line code violation event.

  // ========================================================
  // Address decode shared by the read and write paths.
  function automatic dsrx_reg_e dsrx_decode(input logic [5:0] idx);
    dsrx_reg_e sel;
    sel = DSRX_REG_NONE;
    if (idx == `DSRX_IDX_IOCTL) begin
      sel = DSRX_REG_IOCTL;
    end else if (idx == `DSRX_IDX_ISTS) begin
      sel = DSRX_REG_ISTS;
    end else if (idx == `DSRX_IDX_IMSK) begin
      sel = DSRX_REG_IMSK;
    end else if (idx == `DSRX_IDX_LCVCNT) begin
      sel = DSRX_REG_LCVCNT;
    end
    return sel;
  endfunction : dsrx_decode

  // ========================================================
  // Next-state logic for line decode and register bus.
  always_comb begin
    logic single;
    logic ami;
    logic pos;
    logic neg;
    logic mark;
    logic both;
    logic [2:0] npipe;
    logic [`DSRX_INT_W-1:0] ev;
    logic [`DSRX_INT_W-1:0] clr;
    dsrx_reg_e wsel;
    dsrx_reg_e rsel;
    single = 1'b0;
    ami = 1'b0;
    pos = 1'b0;
    neg = 1'b0;
    mark = 1'b0;
    both = 1'b0;
    npipe = 3'h0;
    ev = `DSRX_INT_RESET;
    clr = `DSRX_INT_RESET;
    wsel = DSRX_REG_NONE;
    rsel = DSRX_REG_NONE;
    st_nxt = st_r;
    viol_w = 1'b0;
    sub_w = 1'b0;
    lcv_w = 1'b0;

    // Two flip-flops on every line pin; edges found on stage two.
    st_nxt.meta.clk = rx_recovered_line_clock;
    st_nxt.meta.sym.pos = rx_positive_rail;
    st_nxt.meta.sym.neg = rx_negative_rail;
    st_nxt.sync = st_r.meta;
    st_nxt.clk_d = st_r.sync.clk;
    rise_w = st_r.sync.clk & ~st_r.clk_d;
    fall_w = ~st_r.sync.clk & st_r.clk_d;
    // The control bit picks which line clock edge samples the rails.
    take_w = st_r.ioc[`DSRX_IOC_RXINV] ? fall_w : rise_w;

    single = st_r.ioc[`DSRX_IOC_SINGLE];
    ami = st_r.ioc[`DSRX_IOC_AMI];
    st_nxt.dvalid = 1'b0;

    // Every symbol step is paced by a line clock edge.
    if (take_w) begin
      pos = st_r.sync.sym.pos;
      // Single-rail ignores the idle negative rail.
      neg = single ? 1'b0 : st_r.sync.sym.neg;
      mark = pos | neg;
      both = pos & neg;
      st_nxt.dout = st_r.pipe[2];
      st_nxt.dvalid = 1'b1;
      npipe = {st_r.pipe[1:0], mark};
      if (!single) begin
        // Successive marks must alternate however many zeros lie between.
        viol_w = both | (mark & st_r.seen_mark &
                         (neg == st_r.last_neg));
        if (ami) begin
          lcv_w = viol_w;
        end else begin
          // A violation after a zero closes a 00V or B0V pattern.
          if (viol_w && !both && !st_r.pipe[0]) begin
            sub_w = 1'b1;
            npipe = 3'h0;
          end else if (viol_w) begin
            lcv_w = 1'b1;
          end
          // Three zeros in a row cannot occur in valid B3ZS.
          if (mark) begin
            st_nxt.zrun = 2'h0;
          end else if (st_r.zrun == `DSRX_ZRUN_MAX - 2'h1) begin
            st_nxt.zrun = 2'h0;
            lcv_w = 1'b1;
          end else begin
            st_nxt.zrun = st_r.zrun + 2'h1;
          end
        end
        if (mark && !both) begin
          st_nxt.last_neg = neg;
          st_nxt.seen_mark = 1'b1;
        end
      end
      st_nxt.pipe = npipe;
    end
    st_nxt.lcv_p = lcv_w;
    if (lcv_w) begin
      st_nxt.lcv_cnt = st_r.lcv_cnt + LCV_CNT_W'(1);
    end

    // Write address and data are taken in either order.
    if (!st_r.aw_ok && s_axi_awvalid) begin
      st_nxt.aw_ok = 1'b1;
      st_nxt.aw_idx = s_axi_awaddr[7:2];
    end
    if (!st_r.w_ok && s_axi_wvalid) begin
      st_nxt.w_ok = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.aw_ok && st_r.w_ok && !st_r.bvalid) begin
      wsel = dsrx_decode(st_r.aw_idx);
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = (wsel == DSRX_REG_NONE) ? `DSRX_RESP_SLVERR
                                             : `DSRX_RESP_OKAY;
      if (st_r.wstrb[0]) begin
        if (wsel == DSRX_REG_IOCTL) begin
          st_nxt.ioc = (st_r.ioc & ~`DSRX_IOC_WMASK) |
                       (st_r.wdata[7:0] & `DSRX_IOC_WMASK);
        end else if (wsel == DSRX_REG_ISTS) begin
          clr = st_r.wdata[`DSRX_INT_W-1:0];
        end else if (wsel == DSRX_REG_IMSK) begin
          st_nxt.imsk = st_r.wdata[`DSRX_INT_W-1:0];
        end
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.aw_ok = 1'b0;
      st_nxt.w_ok = 1'b0;
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    ev[`DSRX_INT_LCV] = lcv_w;
    ev[`DSRX_INT_SUBST] = sub_w;
    st_nxt.ists = (st_r.ists & ~clr) | ev;

    // Reads answer one cycle after the address is taken.
    if (!st_r.rvalid && s_axi_arvalid) begin
      rsel = dsrx_decode(s_axi_araddr[7:2]);
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `DSRX_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      if (rsel == DSRX_REG_IOCTL) begin
        st_nxt.rdata[7:0] = st_r.ioc;
      end else if (rsel == DSRX_REG_ISTS) begin
        st_nxt.rdata[`DSRX_INT_W-1:0] = st_r.ists;
      end else if (rsel == DSRX_REG_IMSK) begin
        st_nxt.rdata[`DSRX_INT_W-1:0] = st_r.imsk;
      end else if (rsel == DSRX_REG_LCVCNT) begin
        st_nxt.rdata[LCV_CNT_W-1:0] = st_r.lcv_cnt;
      end else begin
        st_nxt.rresp = `DSRX_RESP_SLVERR;
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // ========================================================
  // State register with synchronous reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.ioc <= `DSRX_IOC_RESET;
      st_r.ists <= `DSRX_INT_RESET;
      st_r.imsk <= `DSRX_INT_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ========================================================
  // Outputs.
  assign rx_data = st_r.dout;
  assign rx_data_valid = st_r.dvalid;
  assign rx_line_code_violation = st_r.lcv_p;
  // Transmit and receive share one rail-format setting.
  assign tx_single_rail = st_r.ioc[`DSRX_IOC_SINGLE];
  assign tx_clk_invert = st_r.ioc[`DSRX_IOC_TXINV];
  assign irq = |(st_r.ists & st_r.imsk);
  assign s_axi_awready = ~st_r.aw_ok;
  assign s_axi_wready = ~st_r.w_ok;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = ~st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  // ========================================================
  // Assertions.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_dual_rail: assert property (
    $rose(aresetn) |-> !tx_single_rail && !st_r.ioc[`DSRX_IOC_RXINV])
    else $error("Reset did not select dual-rail rising edge.");

  a_edge_gives_bit: assert property (
    (st_r.ioc[`DSRX_IOC_RXINV] ? fall_w : rise_w) |=> rx_data_valid)
    else $error("Selected line clock edge gave no bit.");

  a_no_edge_no_bit: assert property (
    !take_w |=> !rx_data_valid)
    else $error("Bit emitted without a line clock edge.");

  a_single_pos_bit: assert property (
    take_w && st_r.ioc[`DSRX_IOC_SINGLE]
    |=> st_r.pipe[0] == $past(st_r.sync.sym.pos))
    else $error("Single-rail bit differs from positive rail.");

  a_ami_pulse_one: assert property (
    take_w && !st_r.ioc[`DSRX_IOC_SINGLE] && st_r.ioc[`DSRX_IOC_AMI] &&
    (st_r.sync.sym.pos ^ st_r.sync.sym.neg) |=> st_r.pipe[0])
    else $error("AMI pulse not decoded as one.");

  a_same_pol_lcv: assert property (
    take_w && !st_r.ioc[`DSRX_IOC_SINGLE] && st_r.ioc[`DSRX_IOC_AMI]
    && st_r.seen_mark && (st_r.sync.sym.pos ^ st_r.sync.sym.neg)
    && (st_r.sync.sym.neg == st_r.last_neg) |=> rx_line_code_violation)
    else $error("Repeated mark polarity not flagged.");

  a_subst_zeros: assert property (
    sub_w |=> st_r.pipe == 3'h0 && !rx_line_code_violation &&
      st_r.ists[`DSRX_INT_SUBST])
    else $error("Substitution pattern not replaced by zeros.");

  a_lcv_sets_status: assert property (
    rx_line_code_violation |-> st_r.ists[`DSRX_INT_LCV])
    else $error("Violation did not set its status bit.");

  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data changed before acceptance.");

  a_lcv_counts: assert property (
    rx_line_code_violation |-> st_r.lcv_cnt ==
      LCV_CNT_W'($past(st_r.lcv_cnt) + 1))
    else $error("Violation did not advance the counter.");

  a_bresp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before acceptance.");

endmodule : dsrx_line_rx
`default_nettype wire

// ===== test/dsrx_liu_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Line interface unit model.
// The clock runs only while a symbol is sent and rests at the idle level.
module dsrx_line_unit_model (
  // Line pins towards the receiver.
  output var logic line_clk,
  output var logic pos,
  output var logic neg,
  // Sampling edge and rail format in use.
  input wire logic inv,
  input wire logic single
);
  // Pins start quiet.
  initial begin
    line_clk = 1'h0;
    pos = 1'h0;
    neg = 1'h0;
  end

  // Sends one symbol around the sampling edge.
  // After the hold time the rails turn over, so stale data never looks valid.
  task automatic send(input logic p, input logic n);
    line_clk = inv;
    pos = p;
    neg = single ? 1'h0 : n;
    #62.5 line_clk = ~inv;
    #62.5 line_clk = inv;
    pos = ~p;
    neg = single ? 1'h0 : ~n;
  endtask : send
endmodule : dsrx_line_unit_model
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dsrx_defs.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  bad_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module tb;
  // ==========================================================
  // Stimulus and observed signals.
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, tx_single_rail, tx_clk_invert;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rx_recovered_line_clock, rx_positive_rail, rx_negative_rail;
  logic rx_data, rx_data_valid, rx_line_code_violation;
  logic inv_sel = 1'h0, single_sel = 1'h0, pol = 1'h0;
  logic got[$], lcvq[$], sp[$], sn[$], bits[$];
  int bad_count = 0, comparisons = 0, cyc = 0, nb = 0;
  localparam logic [5:0] ioc = `DSRX_IDX_IOCTL;
  localparam logic [5:0] ists = `DSRX_IDX_ISTS;
  localparam logic [5:0] imsk = `DSRX_IDX_IMSK;
  localparam logic [1:0] ok = `DSRX_RESP_OKAY;

  always #5 aclk = ~aclk;

  dsrx_line_rx dut (
    .aclk, .aresetn, .rx_recovered_line_clock, .rx_positive_rail,
    .rx_negative_rail, .rx_data, .rx_data_valid, .rx_line_code_violation,
    .tx_single_rail, .tx_clk_invert, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  dsrx_line_unit_model line_unit (
    .line_clk(rx_recovered_line_clock), .pos(rx_positive_rail),
    .neg(rx_negative_rail), .inv(inv_sel), .single(single_sel)
  );

  // Collects decoded bits and cuts a hang short.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
    if (aresetn && rx_data_valid) begin
      got.push_back(rx_data);
      lcvq.push_back(rx_line_code_violation);
    end
  end

  // Prints the verdict and stops.
  task automatic end_sim();
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  // ==========================================================
  // Mapped indices answer OKAY, all others SLVERR.
  function automatic logic [1:0] resp_of(input logic [5:0] idx);
    return (idx >= ioc && idx <= `DSRX_IDX_LCVCNT) ? ok : `DSRX_RESP_SLVERR;
  endfunction : resp_of

  // Register bus tasks; handshakes are judged on settled values.
  task automatic wr(input logic [5:0] idx, input logic [31:0] wd,
                    input logic [3:0] ws = 4'hF);
    logic aw, w, b;
    logic [1:0] br;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= wd;
    s_axi_wstrb <= ws;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end while (!b);
    s_axi_bready <= 1'h0;
    `CHK("bresp", resp_of(idx), br)
    @(negedge aclk);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [31:0] e,
                    input logic [1:0] er, input string nm);
    logic a, v;
    logic [31:0] rdv;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge aclk);
      a = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      rdv = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'h0;
    end while (!v);
    s_axi_rready <= 1'h0;
    `CHK(nm, e, rdv)
    `CHK("rresp", er, r)
  endtask : rd

  // ==========================================================
  // Line symbol builders; pol is the polarity of the last mark.
  function automatic void sym(input logic p, input logic n);
    sp.push_back(p);
    sn.push_back(n);
  endfunction : sym

  // A violation repeats the last polarity instead of alternating.
  function automatic void mark(input logic viol);
    if (!viol) begin
      pol = ~pol;
      nb++;
    end
    sym(pol, ~pol);
  endfunction : mark

  // Encodes bits as AMI, or with zero substitution when b3 is set.
  function automatic void encode(input logic b3);
    for (int i = 0; i < bits.size(); i++) begin
      if (bits[i]) mark(1'h0);
      else if (b3 && i + 2 < bits.size() && !bits[i+1] && !bits[i+2]) begin
        if (nb % 2) sym(1'h0, 1'h0);
        else mark(1'h0);
        sym(1'h0, 1'h0);
        mark(1'h1);
        nb = 0;
        i += 2;
      end else sym(1'h0, 1'h0);
    end
  endfunction : encode

  // Sends one random burst in a mode and checks the decoded stream.
  // The first eight symbols settle decoder state left by earlier bursts.
  task automatic run(input logic [7:0] ctl, input logic b3, input int elcv);
    int nl;
    nl = 0;
    wr(ioc, {24'h0, ctl});
    inv_sel = ctl[`DSRX_IOC_RXINV];
    single_sel = ctl[`DSRX_IOC_SINGLE];
    sp = {};
    sn = {};
    bits = {};
    for (int i = 0; i < 56; i++) begin
      bits.push_back(i < 8 || $urandom_range(2) == 0);
    end
    if (single_sel) begin
      foreach (bits[i]) sym(bits[i], 1'h0);
      repeat (8) sym(1'h1, 1'h0);
    end else begin
      encode(b3);
      mark(1'h0);
      mark(1'h1);
      mark(1'h0);
      repeat (3) sym(1'h0, 1'h0);
      repeat (8) mark(1'h0);
    end
    got = {};
    lcvq = {};
    foreach (sp[i]) line_unit.send(sp[i], sn[i]);
    repeat (10) @(posedge aclk);
    `CHK("symbols", sp.size(), got.size())
    for (int k = 8; k < 56; k++) begin
      `CHK("bit", bits[k], got[k+3])
    end
    for (int k = 8; k < got.size(); k++) if (lcvq[k] !== 1'h0) nl++;
    `CHK("lcv", elcv, nl)
  endtask : run

  // ==========================================================
  // Main sequence.
  initial begin
    void'($urandom(2));
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    `CHK("tx_single", 1'h0, tx_single_rail)
    rd(ioc, 32'hA0, ok, "ioctl");
    rd(imsk, 32'h0, ok, "imsk");
    rd(6'h20, 32'h0, `DSRX_RESP_SLVERR, "unmapped");
    d = $urandom;
    wr(ioc, d);
    rd(ioc, {24'h0, d[7:0] & `DSRX_IOC_WMASK}, ok, "ioctl");
    `CHK("tx_single", d[3], tx_single_rail)
    `CHK("tx_inv", d[2], tx_clk_invert)
    wr(ioc, 32'hFF, 4'hE);
    wr(6'h20, 32'hFF);
    rd(ioc, {24'h0, d[7:0] & `DSRX_IOC_WMASK}, ok, "ioctl_kept");
    run(8'hA8, 1'h0, 0);
    run(8'hAA, 1'h0, 0);
    run(8'hB2, 1'h0, 1);
    run(8'hB0, 1'h0, 1);
    wr(ists, 32'h3);
    run(8'hA0, 1'h1, 2);
    rd(ists, 32'h3, ok, "ists");
    `CHK("irq", 1'h0, irq)
    wr(imsk, 32'h2);
    `CHK("irq", 1'h1, irq)
    wr(ists, 32'h2);
    `CHK("irq", 1'h0, irq)
    rd(ists, 32'h1, ok, "ists");
    end_sim();
  end
endmodule : tb
`default_nettype wire
